// ===== rtl/ssrx_consts.svh
// Offsets, field positions, reset values and timing counts of the serial engine.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef SSRX_CONSTS_SVH
`define SSRX_CONSTS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SSRX_OFS_CTRL 4'h0
`define SSRX_OFS_STAT 4'h4
`define SSRX_OFS_RXB 4'h8
`define SSRX_OFS_TXB 4'hc
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define SSRX_CR_START 7
`define SSRX_CR_STOP 6
`define SSRX_CR_MODE_HI 5
`define SSRX_CR_MODE_LO 4
`define SSRX_CR_DIR 3
`define SSRX_CR_SCK_HI 2
`define SSRX_CR_SCK_LO 0
// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
`define SSRX_SR_ACTIVE 7
`define SSRX_SR_PARTIAL 6
`define SSRX_SR_TXE 5
`define SSRX_SR_RXF 4
`define SSRX_SR_TX_UNDERRUN_FLAG 3
`define SSRX_SR_RX_OVERRUN_FLAG 2
// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define SSRX_CTRL_RST 8'h00
`define SSRX_BUF_RST 8'h00
`define SSRX_MODE_TX 2'h0
`define SSRX_MODE_RX 2'h1
`define SSRX_MODE_TXRX 2'h2
`define SSRX_SCK_EXT 3'h7
`define SSRX_BITS 4'h8
// ------------------------------------------------------------
// Timing: clock 100 MHz, fc taken as the system clock
// ------------------------------------------------------------
`define SSRX_CLK_MHZ 100
`define SSRX_FC_DIV_MAX_LOG 12
`endif

// ===== rtl/ssrx_pkg.sv
// Types shared by the serial engine and its clock generator.
// Assumes the consts header is compiled alongside.
package ssrx_pkg;
  typedef enum logic [1:0] {
    SSRX_IDLE = 2'b00,
    SSRX_SHIFT = 2'b01,
    SSRX_WAIT = 2'b11,
    SSRX_ENDING = 2'b10
  } ssrx_state_t;
  typedef logic [7:0] ssrx_byte_t;
endpackage

// ===== rtl/ssrx_sck_if.sv
// Carrier between the engine and its shift-clock generator.
// Assumes one clock domain; used only between the two design modules.
`timescale 1ns/10ps
interface ssrx_sck_if;
  logic run;
  logic [2:0] sel;
  logic sck;
  logic fall;
  logic rise;
  modport gen (input run, input sel, output sck, output fall, output rise);
  modport eng (output run, output sel, input sck, input fall, input rise);
endinterface

// ===== rtl/ssrx_sck_gen.sv
// Internal shift-clock generator with synchronised external clock edges.
// Assumes clk_i at 100 MHz; external clock pin is asynchronous.
`timescale 1ns/10ps
`include "ssrx_consts.svh"
module ssrx_sck_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_pin_i,
  ssrx_sck_if.gen sk
);
  import ssrx_pkg::*;
  typedef struct packed {
    logic [11:0] div;
    logic sck;
    logic s1;
    logic s2;
    logic s3;
  } ssrx_gen_t;
  ssrx_gen_t q, d;
  logic ext;
  logic [11:0] half;
  assign ext = (sk.sel == `SSRX_SCK_EXT);
  // Half period: sel 0 gives fc/2^12, sel 1..6 give fc/2^8..fc/2^3
  always_comb begin
    unique case (sk.sel)
      3'h0: half = 12'h7ff;
      3'h1: half = 12'h07f;
      3'h2: half = 12'h03f;
      3'h3: half = 12'h01f;
      3'h4: half = 12'h00f;
      3'h5: half = 12'h007;
      3'h6: half = 12'h003;
      default: half = 12'h003;
    endcase
  end
  always_comb begin
    d = q;
    d.s1 = sck_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (!sk.run || ext) begin
      // Parking high is the idle level; a stall always ends on a full half period
      d.div = 12'h000;
      d.sck = 1'b1;
    end else if (q.div >= half) begin
      d.div = 12'h000;
      d.sck = ~q.sck;
    end else begin
      d.div = q.div + 12'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{div: 12'h000, sck: 1'b1, s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      q <= d;
    end
  end
  assign sk.sck = ext ? q.s2 : q.sck;
  assign sk.fall = ext ? (q.s3 & ~q.s2) : (q.sck & ~d.sck);
  assign sk.rise = ext ? (~q.s3 & q.s2) : (~q.sck & d.sck);
endmodule

// ===== rtl/ssrx_engine.sv
// Eight-bit clocked serial engine with classic Wishbone register slave.
// Assumes single clk_i at 100 MHz; peer clock and data pins are asynchronous.
`timescale 1ns/10ps
`include "ssrx_consts.svh"
module ssrx_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_irq_o
);
  import ssrx_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    ssrx_state_t st;
    logic start;
    logic [1:0] mode;
    logic dir;
    logic [2:0] sck_sel;
    logic active;
    logic partial;
    logic txe;
    logic rx_full_flag;
    logic tx_err;
    logic rx_err;
    logic irq_pend;
    logic irq;
    ssrx_byte_t txb;
    ssrx_byte_t rxb;
    ssrx_byte_t tsr;
    ssrx_byte_t rsr;
    logic [3:0] falls;
    logic [3:0] rises;
    logic so;
    logic ack;
    logic [31:0] rdat;
    logic si1;
    logic si2;
    logic rx_second;
  } ssrx_eng_t;
  ssrx_eng_t q, d;
  ssrx_sck_if sk ();
  ssrx_sck_gen u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sck_pin_i(shift_clock_pin_i),
    .sk(sk)
  );
  logic ext, txm, rxm, req, wr, rd, rd_rxb, wr_txb, wr_ctrl, wr_stat;
  logic tx_ready, rx_ready, can_go;
  ssrx_byte_t rbit_word;
  assign ext = (q.sck_sel == `SSRX_SCK_EXT);
  assign txm = (q.mode == `SSRX_MODE_TX) || (q.mode == `SSRX_MODE_TXRX);
  assign rxm = (q.mode == `SSRX_MODE_RX) || (q.mode == `SSRX_MODE_TXRX);
  assign req = cyc_i & stb_i & ~q.ack;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign rd_rxb = rd & (adr_i == `SSRX_OFS_RXB);
  assign wr_txb = wr & (adr_i == `SSRX_OFS_TXB);
  assign wr_ctrl = wr & (adr_i == `SSRX_OFS_CTRL);
  assign wr_stat = wr & (adr_i == `SSRX_OFS_STAT);
  // Internal auto-wait: a byte may start only when its buffers are ready
  assign tx_ready = ~txm | ~q.txe;
  assign rx_ready = ~rxm | ~q.rx_full_flag;
  assign can_go = ext | (tx_ready & rx_ready);
  // Received bit placed per direction: MSB first shifts left, LSB first right
  assign rbit_word = q.dir ? {q.si2, q.rsr[7:1]} : {q.rsr[6:0], q.si2};
  assign sk.sel = q.sck_sel;
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.si1 = serial_in_pin_i;
    d.si2 = q.si1;
    d.ack = req;
    d.irq = 1'b0;
    if (rd) begin
      unique case (adr_i)
        `SSRX_OFS_CTRL: d.rdat = {24'h0, q.start, 1'b0, q.mode, q.dir, q.sck_sel};
        `SSRX_OFS_STAT: d.rdat = {24'h0, q.active, q.partial, q.txe, q.rx_full_flag,
                                  q.tx_err, q.rx_err, 2'b00};
        `SSRX_OFS_RXB: d.rdat = {24'h0, (q.rx_err && q.rx_second) ? q.rsr : q.rxb};
        default: d.rdat = 32'h0;
      endcase
    end
    // Software side of the flags; hardware sets below take priority
    if (rd_rxb) begin
      d.rx_full_flag = 1'b0;
      if (q.rx_err) begin
        d.rx_second = 1'b1;
      end
    end
    if (wr_txb && q.txe) begin
      d.txb = dat_i[7:0];
      d.txe = 1'b0;
    end
    if (wr_stat) begin
      if (!dat_i[`SSRX_SR_TX_UNDERRUN_FLAG]) begin
        d.tx_err = 1'b0;
      end
      if (!dat_i[`SSRX_SR_RX_OVERRUN_FLAG]) begin
        d.rx_err = 1'b0;
        d.rx_full_flag = 1'b0;
        d.rx_second = 1'b0;
      end
    end
    if (wr_ctrl) begin
      d.start = dat_i[`SSRX_CR_START];
      if (!q.active) begin
        // Mode, direction and clock are only safe to change while idle
        d.mode = dat_i[`SSRX_CR_MODE_HI:`SSRX_CR_MODE_LO];
        d.dir = dat_i[`SSRX_CR_DIR];
        d.sck_sel = dat_i[`SSRX_CR_SCK_HI:`SSRX_CR_SCK_LO];
      end
    end
    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    unique case (q.st)
      SSRX_IDLE: begin
        d.falls = 4'h0;
        d.rises = 4'h0;
        if (q.start && (can_go || ext) && q.mode != 2'h3) begin
          d.st = SSRX_SHIFT;
        end
      end
      SSRX_WAIT: begin
        if (!q.start) begin
          d.st = SSRX_ENDING;
        end else if (can_go) begin
          d.st = SSRX_SHIFT;
        end
      end
      SSRX_SHIFT: begin
        if (sk.fall) begin
          if (q.falls == 4'h0) begin
            d.active = 1'b1;
            d.partial = 1'b1;
            if (txm) begin
              if (q.txe) begin
                d.tx_err = 1'b1;
                d.irq_pend = 1'b1;
              end else begin
                d.tsr = q.txb;
              end
            end
            d.so = (txm && !q.txe) ? (q.dir ? q.txb[0] : q.txb[7]) : 1'b1;
            if (txm && !q.txe) begin
              d.tsr = q.dir ? {1'b1, q.txb[7:1]} : {q.txb[6:0], 1'b1};
            end
          end else begin
            d.so = q.dir ? q.tsr[0] : q.tsr[7];
            d.tsr = q.dir ? {1'b1, q.tsr[7:1]} : {q.tsr[6:0], 1'b1};
          end
          d.falls = q.falls + 4'h1;
          if (q.falls == `SSRX_BITS - 4'h1) begin
            d.partial = 1'b0;
          end
          // Transmit-only underrun interrupt comes on the second fall of the byte
          if (q.irq_pend && q.mode == `SSRX_MODE_TX) begin
            d.irq = 1'b1;
            d.irq_pend = 1'b0;
          end
        end
        if (sk.rise && q.falls != 4'h0) begin
          if (q.rises == 4'h0 && txm && !q.tx_err) begin
            d.txe = 1'b1;
          end
          if (rxm && !q.rx_err) begin
            d.rsr = rbit_word;
          end
          d.rises = q.rises + 4'h1;
          if (q.rises == `SSRX_BITS - 4'h1) begin
            d.falls = 4'h0;
            d.rises = 4'h0;
            if (rxm && !q.rx_err) begin
              if (q.rx_full_flag) begin
                d.rx_err = 1'b1;
                d.rx_second = 1'b0;
                d.irq = 1'b1;
              end else begin
                d.rxb = rbit_word;
                d.rx_full_flag = 1'b1;
                d.irq = 1'b1;
              end
            end else if (!rxm && !q.tx_err) begin
              d.irq = 1'b1;
            end
            if (q.irq_pend && rxm) begin
              d.irq = 1'b1;
              d.irq_pend = 1'b0;
            end
            // Peer must respect the stop window with an external clock
            if (!q.start) begin
              d.st = SSRX_ENDING;
            end else if (ext) begin
              d.st = SSRX_SHIFT;
            end else begin
              d.st = SSRX_WAIT;
            end
          end
        end
      end
      SSRX_ENDING: begin
        d.active = 1'b0;
        d.so = 1'b1;
        d.st = SSRX_IDLE;
      end
      default: d.st = SSRX_IDLE;
    endcase
    if (q.tx_err) begin
      d.so = 1'b1;
    end
    if (wr_ctrl && dat_i[`SSRX_CR_STOP]) begin
      // Forced stop wins over everything but a same-cycle interrupt pulse, which still goes out
      d.st = SSRX_IDLE;
      d.start = 1'b0;
      d.active = 1'b0;
      d.partial = 1'b0;
      d.txe = 1'b1;
      d.rx_full_flag = 1'b0;
      d.tx_err = 1'b0;
      d.rx_err = 1'b0;
      d.irq_pend = 1'b0;
      d.rx_second = 1'b0;
      d.txb = `SSRX_BUF_RST;
      d.rxb = `SSRX_BUF_RST;
      d.tsr = `SSRX_BUF_RST;
      d.rsr = `SSRX_BUF_RST;
      d.falls = 4'h0;
      d.rises = 4'h0;
      d.so = 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= SSRX_IDLE;
      q.txe <= 1'b1;
      q.so <= 1'b1;
      q.si1 <= 1'b1;
      q.si2 <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // Clock runs only while shifting and only when internal
  assign sk.run = (q.st == SSRX_SHIFT) && !ext;
  assign shift_clock_pin_o = sk.sck;
  assign shift_clock_pin_oe_n_o = ext;
  assign serial_out_pin_o = q.so;
  assign serial_irq_o = q.irq;
  assign dat_o = q.rdat;
  assign ack_o = q.ack;
endmodule

// ===== bench/ssrx_peer.sv
// Peer model of the far serial device: shifts on the wire clock.
// Assumes the bench resolves the shared clock wire and feeds it back.
`timescale 1ns/10ps
module ssrx_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic so_i,
  input wire logic lsb_i,
  input wire logic go_i,
  input wire logic [7:0] tx_i,
  output logic sck_o,
  output logic si_o,
  output logic [7:0] rx_o
);
  logic p_q;
  logic [2:0] n_q;
  logic [7:0] sh_q;
  logic [7:0] nx;
  logic [6:0] c_q;
  assign nx = lsb_i ? {so_i, sh_q[7:1]} : {sh_q[6:0], so_i};
  // ------
  // Clock frames: 8 pulses of 6 cycles a half, idle high between
  // ------
  always @(posedge clk_i) begin
    p_q <= sck_i;
    sck_o <= (c_q == 7'h0) || (((c_q - 7'h1) / 7'h6) % 7'h2 == 7'h0);
    if (go_i) c_q <= 7'h60;
    else if (c_q != 7'h0) c_q <= c_q - 7'h1;
    if (p_q && !sck_i) si_o <= lsb_i ? tx_i[n_q] : tx_i[3'h7 - n_q];
    if (!p_q && sck_i) begin
      sh_q <= nx;
      n_q <= n_q + 3'h1;
      if (n_q == 3'h7) rx_o <= nx;
    end
    if (rst_i) begin
      c_q <= 7'h0;
      n_q <= 3'h0;
      si_o <= 1'b1;
      rx_o <= 8'h00;
    end
  end
endmodule

// ===== bench/ssrx_engine_sva.sv
// Checker for the engine's bus handshake, reset levels and clock pin.
// Assumes it is bound to the engine and sees only its ports.
`timescale 1ns/10ps
`include "ssrx_consts.svh"
module ssrx_engine_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic shift_clock_pin_i,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe_n_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_irq_o
);
  logic cw;
  assign cw = ack_o && we_i && cyc_i && stb_i && sel_i[0] && adr_i == `SSRX_OFS_CTRL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // Assertions
  // ------
  chk_ack_latency: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_irq_pulse: assert property (serial_irq_o |=> !serial_irq_o)
    else $error("irq too long");
  chk_unmap_zero: assert property (ack_o && !we_i && !(adr_i inside
    {`SSRX_OFS_CTRL, `SSRX_OFS_STAT, `SSRX_OFS_RXB}) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  // The select lands at the edge that raises ack, so the pin moves in the ack cycle
  chk_oe_ext_sel: assert property ($rose(shift_clock_pin_oe_n_o) |->
    (cw && dat_i[2:0] == `SSRX_SCK_EXT))
    else $error("clock pin released without select");
  chk_oe_int_sel: assert property ($fell(shift_clock_pin_oe_n_o) |->
    (cw && dat_i[2:0] != `SSRX_SCK_EXT))
    else $error("clock pin driven without select");
  // Own disable: this one looks at the reset itself
  chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> (!ack_o && !serial_irq_o
    && serial_out_pin_o && shift_clock_pin_o && dat_o == 32'h0))
    else $error("reset levels wrong");
  cov_write: cover property (ack_o && we_i);
  cov_irq: cover property (serial_irq_o);
  cov_ext: cover property ($rose(shift_clock_pin_oe_n_o));
endmodule
bind ssrx_engine ssrx_engine_sva u_ssrx_engine_sva (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .shift_clock_pin_i, .shift_clock_pin_o,
  .shift_clock_pin_oe_n_o, .serial_in_pin_i, .serial_out_pin_o, .serial_irq_o);

// ===== bench/ssrx_engine_tb.sv
// Bench for the serial engine: Wishbone tasks, peer wiring, scenarios.
// Assumes the peer model and the bound checker are compiled first.
`timescale 1ns/10ps
`include "ssrx_consts.svh"
module ssrx_engine_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, sck, oe_n, so, irq;
  logic p_sck, p_si, p_lsb, p_go, sck_w;
  logic [3:0] adr, sel;
  logic [31:0] dat, rdat;
  logic [7:0] p_tx, p_rx, q;
  int err_count = 0, n_checks = 0, irq_cnt = 0;
  // Clock wire resolves to whoever owns it
  assign sck_w = oe_n ? p_sck : sck;
  ssrx_engine u_ssrx_engine (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck), .shift_clock_pin_oe_n_o(oe_n),
    .serial_in_pin_i(p_si), .serial_out_pin_o(so), .serial_irq_o(irq));
  ssrx_peer u_ssrx_peer (.clk_i, .rst_i, .sck_i(sck_w), .so_i(so), .lsb_i(p_lsb),
    .go_i(p_go), .tx_i(p_tx), .sck_o(p_sck), .si_o(p_si), .rx_o(p_rx));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // ------
  // Shared tasks
  // ------
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is seen at an edge; bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    i = 0;
    do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin err_count++; print_verdict(); end
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic wait_irq(input int n);
    int i;
    for (i = 0; i < 3000 && irq_cnt < n; i++) @(posedge clk_i);
    if (irq_cnt < n) begin err_count++; print_verdict(); end
  endtask
  task automatic ext_byte(input logic [7:0] b);
    p_tx <= b; p_go <= 1'b1;
    @(posedge clk_i);
    p_go <= 1'b0;
    repeat (110) @(posedge clk_i);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    rd(`SSRX_OFS_STAT, 8'h20);
    rd(`SSRX_OFS_CTRL, 8'h00);
    rd(`SSRX_OFS_RXB, 8'h00);
    rd(`SSRX_OFS_TXB, 8'h00);
    rd(4'h1, 8'h00);
  endtask
  task automatic t_rx_int();
    p_lsb <= 1'b0; p_tx <= 8'ha5;
    wb(1'b1, `SSRX_OFS_CTRL, 8'h96);
    wait_irq(1);
    rd(`SSRX_OFS_STAT, 8'hb0);
    repeat (40) @(posedge clk_i);
    chk({7'h0, sck}, 8'h01);
    p_tx <= 8'h3c;
    rd(`SSRX_OFS_RXB, 8'ha5);
    repeat (20) @(posedge clk_i);
    wb(1'b1, `SSRX_OFS_CTRL, 8'h16);
    wait_irq(2);
    rd(`SSRX_OFS_RXB, 8'h3c);
    repeat (40) @(posedge clk_i);
    rd(`SSRX_OFS_STAT, 8'h20);
    chk({7'h0, so}, 8'h01);
  endtask
  task automatic t_txrx_int();
    p_lsb <= 1'b1; p_tx <= 8'hc3;
    wb(1'b1, `SSRX_OFS_TXB, 8'h5a);
    rd(`SSRX_OFS_STAT, 8'h00);
    wb(1'b1, `SSRX_OFS_CTRL, 8'hae);
    wait_irq(3);
    rd(`SSRX_OFS_STAT, 8'hb0);
    chk(p_rx, 8'h5a);
    rd(`SSRX_OFS_RXB, 8'hc3);
    repeat (60) @(posedge clk_i);
    chk({7'h0, sck}, 8'h01);
    wb(1'b1, `SSRX_OFS_CTRL, 8'h40);
    rd(`SSRX_OFS_STAT, 8'h20);
    rd(`SSRX_OFS_CTRL, 8'h2e);
  endtask
  // Skips the buffer read between bytes on purpose to force an overrun
  task automatic t_ext_rx();
    p_lsb <= 1'b0;
    wb(1'b1, `SSRX_OFS_CTRL, 8'h97);
    chk({7'h0, oe_n}, 8'h01);
    ext_byte(8'h81);
    wait_irq(4);
    ext_byte(8'h42);
    wait_irq(5);
    rd(`SSRX_OFS_STAT, 8'hb4);
    ext_byte(8'h24);
    chk(8'(irq_cnt), 8'h05);
    wb(1'b1, `SSRX_OFS_CTRL, 8'h17);
    rd(`SSRX_OFS_RXB, 8'h81);
    rd(`SSRX_OFS_RXB, 8'h42);
    wb(1'b1, `SSRX_OFS_STAT, 8'h00);
    wb(1'b0, `SSRX_OFS_STAT, 8'h00);
    chk(q & 8'h3c, 8'h20);
    wb(1'b1, `SSRX_OFS_CTRL, 8'h40);
  endtask
  task automatic t_ext_tx();
    wb(1'b1, `SSRX_OFS_CTRL, 8'ha7);
    ext_byte(8'h11);
    chk({7'h0, so}, 8'h01);
    chk(p_rx, 8'hff);
    wait_irq(6);
    rd(`SSRX_OFS_STAT, 8'hb8);
    rd(`SSRX_OFS_RXB, 8'h11);
    wb(1'b1, `SSRX_OFS_CTRL, 8'h40);
    rd(`SSRX_OFS_STAT, 8'h20);
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h1;
    dat = 32'h0; p_lsb = 1'b0; p_go = 1'b0; p_tx = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_rx_int();
    t_txrx_int();
    t_ext_rx();
    t_ext_tx();
    print_verdict();
  end
endmodule
